// *** pursq_board.sv ***
// Board strap model for the sequencer.
// Assumes sel 0 means all straps correct.
`timescale 1ns/1ps
`default_nettype none
module pursq_board (
  // Fault select
  input  wire logic [1:0] sel,
  // Straps
  output logic            chip_en_n,
  output logic            cfg_req_n,
  output logic            cfg_stat_n
);
  assign chip_en_n  = (sel == 2'h1);
  assign cfg_req_n  = (sel != 2'h2);
  assign cfg_stat_n = (sel != 2'h3);
endmodule // pursq_board
`default_nettype wire

// *** pursq_checker.sv ***
// Port checker for the sequencer top.
// Assumes one clock; bound to every top instance.
`timescale 1ns/1ps
`default_nettype none
module pursq_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Straps
  input wire logic chip_en_n,
  input wire logic cfg_req_n,
  input wire logic cfg_stat_n,
  // Outputs
  input wire logic cfg_done_o,
  input wire logic cfg_done_oe,
  input wire logic core_rst_n,
  input wire logic ready,
  input wire logic strap_ok
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ready_core_a: assert property (ready == core_rst_n) else $error("ready split");
  done_zero_a: assert property (cfg_done_o == 1'h0) else $error("done level");
  hold_oe_a: assert property (!ready |-> cfg_done_oe) else $error("pin free");
  strap_dec_a: assert property
    (strap_ok == (!chip_en_n && cfg_req_n && cfg_stat_n)) else $error("strap decode");
  bad_oe_a: assert property (ready && !strap_ok |=> cfg_done_oe) else $error("bad");
  good_oe_a: assert property (ready && strap_ok |=> !cfg_done_oe) else $error("ok");
  ready_stay_a: assert property (ready |=> ready) else $error("ready drop");
  por_hold_a: assert property ($rose(rst_n) |-> !ready [*8]) else $error("por");
  oe_fall_a: assert property ($fell(cfg_done_oe) |-> ready) else $error("early float");
  cover property ($rose(ready));
  cover property (ready && !strap_ok);
  cover property ($fell(cfg_done_oe));
endmodule // pursq_checker
bind pursq_top pursq_checker chk (.mclk, .rst_n, .chip_en_n, .cfg_req_n, .cfg_stat_n,
  .cfg_done_o, .cfg_done_oe, .core_rst_n, .ready, .strap_ok);
`default_nettype wire

// *** pursq_counter.v ***
// Saturating cycle counter with a terminal flag.
// Assumes an asynchronous clear from the design's released reset.
`timescale 1ns/1ps
`default_nettype none

module pursq_counter #(
  parameter       W     = 21,
  parameter [W-1:0] LIMIT = 21'h1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // Control
  input  wire         run,
  // Status
  output reg  [W-1:0] count_q,
  output wire         done
);

  assign done = (count_q >= LIMIT);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= {W{1'b0}};
    end else if (run && !done) begin
      count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // pursq_counter

`default_nettype wire

// *** pursq_defines.vh ***
// Constants for the power-up reset sequencer.
// Assumes a 25 MHz core clock; included by bare name.
`ifndef PURSQ_DEFINES_VH
`define PURSQ_DEFINES_VH

// Core clock period in picoseconds
`define PURSQ_CLK_PERIOD_PS 40000
// Extra hold time in the delayed mode, milliseconds
`define PURSQ_DELAY_MS      50
// Delay in clock cycles: 50 ms of 40 ns clocks is 1250000, sized to the counter
`define PURSQ_DELAY_CYC     21'h1312D0
// Counter width, enough for 1250000
`define PURSQ_CNT_W         21
// Power-on reset stretch after the synchroniser, in cycles
`define PURSQ_POR_CYC       5'h10
`define PURSQ_POR_W         5
// Required strap levels {status, request, enable}: high, high, low
`define PURSQ_STRAP_WANT    3'h6
// Mode codes
`define PURSQ_MODE_INSTANT  1'h0
`define PURSQ_MODE_DELAYED  1'h1

`endif

// *** pursq_top.v ***
// Power-up reset sequencer: immediate or 50 ms delayed release.
// Assumes one 25 MHz clock and board straps held after power-up.
`timescale 1ns/1ps
`default_nettype none
`include "pursq_defines.vh"

// Notes on behaviour
// - Two power-up modes: immediate, or with an added 50 ms delay.
// - Immediate mode: usable soon after supply is safe, no configuration step.
// - Power-on reset sets every register to its start value before operation.
// - After power-on reset, done output floats if straps are correct.
// - Delayed mode holds the device in reset 50 ms longer.
// - Done output driven low during delay, floats after 50 ms if straps are correct.
// - No configuration, emulation, upgrade or decryption mechanism exists.
module pursq_top #(
  parameter       MODE      = `PURSQ_MODE_DELAYED,
  parameter [`PURSQ_CNT_W-1:0] DELAY_CYC = `PURSQ_DELAY_CYC
) (
  // Clock and power-on reset
  input  wire mclk,
  input  wire rst_n,
  // Board strap inputs
  input  wire chip_en_n,
  input  wire cfg_req_n,
  input  wire cfg_stat_n,
  // Configuration-done pin
  output wire cfg_done_o,
  output wire cfg_done_oe,
  // Core reset and status
  output wire core_rst_n,
  output wire ready,
  output wire strap_ok
);

  localparam [1:0] ST_POR   = 2'h0;
  localparam [1:0] ST_DELAY = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;
  // Required strap levels: bit 0 enable, bit 1 request, bit 2 status
  localparam [2:0] STRAP_WANT = `PURSQ_STRAP_WANT;

  // Reset release and power-on stretch
  reg                    rsync1_q;
  reg                    rsync2_q;
  reg  [`PURSQ_POR_W-1:0] por_cnt_q;
  wire                   por_done;

  // Sequencer
  reg  [1:0]             state_q;
  reg  [1:0]             state_d;
  reg                    oe_q;
  reg                    oe_d;
  reg                    run_q;
  reg                    run_d;
  wire                   in_delay;
  wire                   dly_done;

  // Strap decode
  wire [2:0]             strap_pins;
  wire [2:0]             strap_hit;
  wire                   straps;
  genvar                 gi;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsync1_q <= 1'b0;
      rsync2_q <= 1'b0;
    end else begin
      rsync1_q <= 1'b1;
      rsync2_q <= rsync1_q;
    end
  end

  always @(posedge mclk or negedge rsync2_q) begin
    if (!rsync2_q) begin
      por_cnt_q <= {`PURSQ_POR_W{1'b0}};
    end else if (!por_done) begin
      por_cnt_q <= por_cnt_q + {{(`PURSQ_POR_W-1){1'b0}}, 1'b1};
    end
  end
  // Count stops at its limit, so the done flag stays up
  assign por_done = (por_cnt_q == `PURSQ_POR_CYC);

  assign strap_pins = {cfg_stat_n, cfg_req_n, chip_en_n};
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_strap
      // One comparator per strap pin
      assign strap_hit[gi] = (strap_pins[gi] == STRAP_WANT[gi]);
    end
  endgenerate
  // A bad strap keeps the done pin low but never stops the core
  assign straps   = &strap_hit;
  assign strap_ok = straps;

  // Delay counter, 50 ms of clocks
  // Cleared only by reset, so the run state can never re-arm it
  assign in_delay = (state_q == ST_DELAY);
  pursq_counter #(
    .W     (`PURSQ_CNT_W),
    .LIMIT (DELAY_CYC)
  ) u_dly (
    .clk     (mclk),
    .rst_n   (rsync2_q),
    .run     (in_delay),
    .count_q (),
    .done    (dly_done)
  );

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_POR: begin
        if (por_done) begin
          if (MODE == `PURSQ_MODE_DELAYED) begin
            state_d = ST_DELAY;
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_DELAY: begin
        if (dly_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        // Only a new power-on reset leaves this state
        state_d = ST_RUN;
      end
      default: begin
        // Unused code: restart the sequence
        state_d = ST_POR;
      end
    endcase
  end

  // Done pin driven low until running
  always @* begin
    // Pin driven unless the run state says otherwise
    oe_d = 1'b1;
    case (state_q)
      ST_POR: begin
        oe_d = 1'b1;
      end
      ST_DELAY: begin
        oe_d = 1'b1;
      end
      ST_RUN: begin
        oe_d = !straps;
      end
      default: begin
        oe_d = 1'b1;
      end
    endcase
  end

  // Core held in reset until run
  always @* begin
    // Core held unless running
    run_d = 1'b0;
    case (state_q)
      ST_POR: begin
        run_d = 1'b0;
      end
      ST_DELAY: begin
        run_d = 1'b0;
      end
      ST_RUN: begin
        run_d = 1'b1;
      end
      default: begin
        run_d = 1'b0;
      end
    endcase
  end

  always @(posedge mclk or negedge rsync2_q) begin
    if (!rsync2_q) begin
      state_q <= ST_POR;
    end else begin
      state_q <= state_d;
    end
  end

  // Pin starts driven low
  // Driven from reset on, so the board never sees an early done
  always @(posedge mclk or negedge rsync2_q) begin
    if (!rsync2_q) begin
      oe_q <= 1'b1;
    end else begin
      oe_q <= oe_d;
    end
  end

  // Core starts in reset
  // One flop for both core outputs keeps them in step
  always @(posedge mclk or negedge rsync2_q) begin
    if (!rsync2_q) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  // Driven low while held
  // Pin only ever drives low; the board's pull-up gives the high level
  assign cfg_done_o  = 1'b0;
  assign cfg_done_oe = oe_q;
  // No configuration logic; core just leaves reset
  assign core_rst_n  = run_q;
  assign ready       = run_q;

endmodule // pursq_top

`default_nettype wire

// *** pursq_top_tb.sv ***
// Bench: both modes side by side, two reset runs.
// Assumes delay shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "pursq_defines.vh"
module pursq_top_tb;
  // Expected counts: two sync edges, stretch, state edge, output flop
  localparam int DLY = 20;
  localparam int IMM_LAT = `PURSQ_POR_CYC + 4;
  logic mclk = 0, rst_n = 0;
  logic [1:0] sel = 0;
  wire en_n, rq_n, st_n, oe_d, oe_i, rd_d, rd_i, do_d, cr_d, ok_d;
  int err_count = 0, n_compared = 0, t, td, r;
  initial forever #20 mclk = ~mclk;
  pursq_board brd (.sel(sel), .chip_en_n(en_n), .cfg_req_n(rq_n), .cfg_stat_n(st_n));
  pursq_top #(.MODE(1'h1), .DELAY_CYC(21'h14)) dut (.mclk(mclk), .rst_n(rst_n),
    .chip_en_n(en_n), .cfg_req_n(rq_n), .cfg_stat_n(st_n), .cfg_done_o(do_d),
    .cfg_done_oe(oe_d), .core_rst_n(cr_d), .ready(rd_d), .strap_ok(ok_d));
  pursq_top #(.MODE(1'h0), .DELAY_CYC(21'h14)) dut_i (.mclk(mclk), .rst_n(rst_n),
    .chip_en_n(en_n), .cfg_req_n(rq_n), .cfg_stat_n(st_n), .cfg_done_o(),
    .cfg_done_oe(oe_i), .core_rst_n(), .ready(rd_i), .strap_ok());
  task chk(string nm, logic e, logic g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask
  task chk_n(string nm, int e, int g);
    n_compared++;
    if (g != e) begin
      err_count++;
      $display("CHECK FAILED %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task step;
    @(posedge mclk);
    #1;
  endtask
  initial begin
    r = $urandom(27);
    repeat (12) step;
    begin : run_all
      for (int k = 0; k < 2; k++) begin
        // Second pass resets in mid-run
        rst_n = 0;
        step;
        chk("ready_rst", 1'b0, rd_d);
        chk("core_rst", 1'b0, cr_d);
        chk("oe_rst", 1'b1, oe_d);
        rst_n = 1;
        t = 0;
        td = 0;
        while (rd_d !== 1'b1 && td < 200) begin
          step;
          td++;
          if (rd_i !== 1'b1) t = td;
          else if (rd_d !== 1'b1) chk("oe_delay", 1'b1, oe_d);
          chk("done_lvl", 1'b0, do_d);
        end
        if (td == 200) begin
          err_count++;
          disable run_all;
        end
        chk_n("imm_lat", IMM_LAT, t + 1);
        chk_n("delay_len", DLY + 1, td - t - 1);
        step;
        chk("oe_free", 1'b0, oe_d);
        for (int i = 0; i < 20; i++) begin
          sel = 2'($urandom % 4);
          step;
          chk("strap_ok", sel == 2'h0, ok_d);
          step;
          chk("oe_strap", sel != 2'h0, oe_d);
          chk("core_run", 1'b1, cr_d);
          chk("run_on", 1'b1, rd_i);
        end
        sel = 0;
        step;
        $display("test %0d done", k);
      end
    end
    give_verdict;
  end
endmodule // pursq_top_tb
`default_nettype wire
